// ==== src/fcs_bus_cycle.sv ====
// One read or write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"
module fcs_bus_cycle (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  input  wire logic                  req_valid,
  input  wire fcs_pkg::fcs_req_type  req,
  output logic                       req_ready,
  output logic                       done_q,
  output logic [15:0]                rdata_q,
  output fcs_pkg::fcs_pins_type      pins_q,
  input  wire logic [15:0]           dq_in
);
  import fcs_pkg::*;

  fcs_cyc_type            st_q;
  logic [`FCS_CNT_W-1:0]  cnt_q;
  logic [15:0]            dq_s1_q;
  logic [15:0]            dq_s2_q;
  logic                   take;
  logic                   cnt_zero;

  assign req_ready = (st_q == fcs_cy_idle);
  assign take      = req_valid && req_ready;
  assign cnt_zero  = (cnt_q == '0);

  // Data pins come from the device's timing, not ours
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else if (clk_en) begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= fcs_cy_idle;
      cnt_q   <= '0;
      done_q  <= 1'b0;
      rdata_q <= 16'h0000;
      pins_q  <= `FCS_PINS_IDLE;
    end else if (clk_en) begin
      done_q <= 1'b0;
      unique case (st_q)
        fcs_cy_idle: begin
          if (take) begin
            pins_q.addr   <= req.addr;
            pins_q.dq_out <= req.data;
            pins_q.ce_n   <= 1'b0;
            // Gate stays high through a write so no cycle is inhibited
            pins_q.oe_n   <= req.wr;
            pins_q.dq_oe  <= req.wr;
            cnt_q         <= `FCS_RD_LOAD;
            st_q          <= req.wr ? fcs_cy_setup : fcs_cy_read;
          end
        end
        fcs_cy_setup: begin
          // Strobe falls after select, so address is settled at that edge
          pins_q.we_n <= 1'b0;
          cnt_q       <= `FCS_WE_LOAD;
          st_q        <= fcs_cy_strobe;
        end
        fcs_cy_strobe: begin
          // Pulse far wider than the noise filter
          if (cnt_zero) begin
            pins_q.we_n <= 1'b1;
            st_q        <= fcs_cy_hold;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        fcs_cy_hold: begin
          pins_q.ce_n  <= 1'b1;
          pins_q.dq_oe <= 1'b0;
          done_q       <= 1'b1;
          st_q         <= fcs_cy_idle;
        end
        fcs_cy_read: begin
          // Wait covers access time plus the two sync stages
          if (cnt_zero) begin
            rdata_q     <= dq_s2_q;
            pins_q.ce_n <= 1'b1;
            pins_q.oe_n <= 1'b1;
            done_q      <= 1'b1;
            st_q        <= fcs_cy_idle;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: st_q <= fcs_cy_idle;
      endcase
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  write_inhibit_a: assert property (!pins_q.we_n |-> pins_q.oe_n && !pins_q.ce_n)
    else $error("strobe low while gate low or select high");
  strobe_width_a: assert property ($fell(pins_q.we_n) |-> !pins_q.we_n [*7])
    else $error("write strobe pulse too short");
  latch_stable_a: assert property (!pins_q.we_n && $past(!pins_q.we_n)
      |-> $stable(pins_q.addr) && $stable(pins_q.dq_out) && pins_q.dq_oe)
    else $error("address or data moved during strobe");
  no_contention_a: assert property (!pins_q.oe_n |-> !pins_q.dq_oe)
    else $error("host drives data while device may drive");
endmodule // fcs_bus_cycle
`default_nettype wire

// ==== src/fcs_defs.svh ====
// Constants for the flash command sequencer host: timing, keys, register map
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

`define FCS_CLK_NS      8
`define FCS_WE_LOW_NS   50
`define FCS_ACC_NS      90
`define FCS_CNT_W       4
`define FCS_WE_LOAD     4'(((`FCS_WE_LOW_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS) - 1)
`define FCS_RD_LOAD     4'(((`FCS_ACC_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS) + 1)

`define FCS_UNLOCK_A1   16'h5555
`define FCS_UNLOCK_A2   16'h2aaa
`define FCS_KEY1        16'h00aa
`define FCS_KEY2        16'h0055
`define FCS_CODE_SETUP  16'h0080
`define FCS_CODE_PROG   16'h00a0
`define FCS_CODE_CHIP   16'h0010
`define FCS_CODE_MAIN   16'h0030
`define FCS_CODE_LOCK   16'h0040
`define FCS_CODE_ID     16'h0090
`define FCS_CODE_EXIT   16'h00f0
`define FCS_TOGGLE_BIT  6

`define FCS_OFF_CTRL    12'h000
`define FCS_OFF_ADDR    12'h004
`define FCS_OFF_WDATA   12'h008
`define FCS_OFF_STAT    12'h00c
`define FCS_OFF_RDATA   12'h010
`define FCS_OFF_POLLS   12'h014
`define FCS_CMD_MSB     2
`define FCS_STAT_BUSY   0
`define FCS_STAT_DONE   1
`define FCS_STAT_REJ    2

`define FCS_PINS_IDLE   {16'h0000, 16'h0000, 1'b0, 1'b1, 1'b1, 1'b1}

`endif

// ==== src/fcs_host_ctrl.sv ====
// APB-controlled host that issues command sequences to the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"
module fcs_host_ctrl (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output logic [15:0]       word_address_lines,
  output logic [15:0]       word_data_lines_o,
  output logic              word_data_lines_oe,
  input  wire logic [15:0]  word_data_lines_i,
  output logic              chip_sel_n,
  output logic              out_gate_n,
  output logic              wr_strobe_n
);
  import fcs_pkg::*;

  // Command length in bus writes or reads
  function automatic logic [2:0] fcs_len(input fcs_cmd_type c);
    unique case (c)
      fcs_cmd_read, fcs_cmd_id_exit1:       fcs_len = 3'd1;
      fcs_cmd_prog:                         fcs_len = 3'd4;
      fcs_cmd_id_entry, fcs_cmd_id_exit3:   fcs_len = 3'd3;
      default:                              fcs_len = 3'd6;
    endcase
  endfunction

  // Self-timed commands finish by toggle polling
  function automatic logic fcs_timed(input fcs_cmd_type c);
    fcs_timed = (c == fcs_cmd_prog) || (c == fcs_cmd_chip_erase) ||
                (c == fcs_cmd_main_erase) || (c == fcs_cmd_lock);
  endfunction

  // Bus cycle for step s of command c; upper byte of keys is zero
  function automatic fcs_req_type fcs_step(input fcs_cmd_type c, input logic [2:0] s,
                                           input logic [15:0] a, input logic [15:0] d);
    fcs_req_type r;
    r = '{wr: 1'b1, addr: `FCS_UNLOCK_A1, data: `FCS_KEY1};
    if (s == 3'd1 || s == 3'd4) begin
      r.addr = `FCS_UNLOCK_A2;
      r.data = `FCS_KEY2;
    end else if (s == 3'd2) begin
      r.data = (c == fcs_cmd_prog)     ? `FCS_CODE_PROG :
               (c == fcs_cmd_id_entry) ? `FCS_CODE_ID :
               (c == fcs_cmd_id_exit3) ? `FCS_CODE_EXIT : `FCS_CODE_SETUP;
    end else if (s == 3'd5) begin
      r.data = (c == fcs_cmd_chip_erase) ? `FCS_CODE_CHIP :
               (c == fcs_cmd_main_erase) ? `FCS_CODE_MAIN : `FCS_CODE_LOCK;
    end
    if (c == fcs_cmd_read)
      r = '{wr: 1'b0, addr: a, data: 16'h0000};
    if (c == fcs_cmd_id_exit1)
      r = '{wr: 1'b1, addr: a, data: `FCS_CODE_EXIT};
    if (c == fcs_cmd_prog && s == 3'd3)
      r = '{wr: 1'b1, addr: a, data: d};
    return r;
  endfunction

  fcs_st_type    st_q;
  fcs_cmd_type   cmd_q;
  logic [2:0]    step_q;
  logic [15:0]   addr_q;
  logic [15:0]   data_q;
  logic [15:0]   rdata_q;
  logic [31:0]   polls_q;
  logic          prev6_q;
  logic          have_prev_q;
  logic          done_q;
  logic          rej_q;

  fcs_req_type   cyc_req;
  fcs_req_type   step_req;
  fcs_pins_type  pins;
  logic          cyc_valid;
  logic          cyc_ready;
  logic          cyc_done;
  logic [15:0]   cyc_rdata;

  // APB decode
  logic wr_en, hit_ctrl, hit_addr, hit_wdata, hit_stat, hit_rdata, hit_polls, mapped;
  logic busy, go, reject, last, taken, stop, finish;
  logic [31:0] stat_word;

  assign hit_ctrl  = (paddr == `FCS_OFF_CTRL);
  assign hit_addr  = (paddr == `FCS_OFF_ADDR);
  assign hit_wdata = (paddr == `FCS_OFF_WDATA);
  assign hit_stat  = (paddr == `FCS_OFF_STAT);
  assign hit_rdata = (paddr == `FCS_OFF_RDATA);
  assign hit_polls = (paddr == `FCS_OFF_POLLS);
  assign mapped    = hit_ctrl | hit_addr | hit_wdata | hit_stat | hit_rdata | hit_polls;

  // Frozen clock means no write can land, so the slave holds off the access
  assign pready  = clk_en;
  assign pslverr = psel && penable && !mapped;
  assign wr_en   = psel && penable && pwrite && clk_en && mapped;

  assign busy   = (st_q != fcs_st_idle);
  assign go     = wr_en && hit_ctrl && !busy;
  // Operands may not move under a running sequence
  assign reject = wr_en && busy && (hit_ctrl || hit_addr || hit_wdata);

  assign stat_word = {29'h0, rej_q, done_q, busy};

  assign prdata = hit_ctrl  ? {29'h0, cmd_q} :
                  hit_addr  ? {16'h0000, addr_q} :
                  hit_wdata ? {16'h0000, data_q} :
                  hit_stat  ? stat_word :
                  hit_rdata ? {16'h0000, rdata_q} :
                  hit_polls ? polls_q : 32'h0000_0000;

  // Sequencing
  assign step_req  = fcs_step(cmd_q, step_q, addr_q, data_q);
  assign cyc_valid = (st_q == fcs_st_issue) || (st_q == fcs_st_poll);
  assign cyc_req   = (st_q == fcs_st_poll) ?
                     fcs_req_type'{wr: 1'b0, addr: addr_q, data: 16'h0000} : step_req;
  assign taken  = cyc_valid && cyc_ready;
  assign last   = (step_q == 3'(fcs_len(cmd_q) - 3'd1));
  // Two reads in a row with the same bit 6 mean the operation has ended
  assign stop   = have_prev_q && (cyc_rdata[`FCS_TOGGLE_BIT] == prev6_q);
  assign finish = cyc_done && (((st_q == fcs_st_wait) && last && !fcs_timed(cmd_q)) ||
                               ((st_q == fcs_st_pwait) && stop));

  fcs_bus_cycle u_cycle (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .req_valid (cyc_valid),
    .req       (cyc_req),
    .req_ready (cyc_ready),
    .done_q    (cyc_done),
    .rdata_q   (cyc_rdata),
    .pins_q    (pins),
    .dq_in     (word_data_lines_i)
  );

  assign word_address_lines = pins.addr;
  assign word_data_lines_o  = pins.dq_out;
  assign word_data_lines_oe = pins.dq_oe;
  assign chip_sel_n         = pins.ce_n;
  assign out_gate_n         = pins.oe_n;
  assign wr_strobe_n        = pins.we_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= 16'h0000;
      data_q <= 16'h0000;
    end else if (wr_en && !busy) begin
      if (hit_addr)
        addr_q <= pwdata[15:0];
      if (hit_wdata)
        data_q <= pwdata[15:0];
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      rej_q  <= 1'b0;
    end else if (clk_en) begin
      done_q <= finish | (done_q & ~(wr_en && hit_stat && pwdata[`FCS_STAT_DONE]));
      rej_q  <= reject | (rej_q & ~(wr_en && hit_stat && pwdata[`FCS_STAT_REJ]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= fcs_st_idle;
      cmd_q       <= fcs_cmd_read;
      step_q      <= 3'd0;
      rdata_q     <= 16'h0000;
      polls_q     <= 32'h0000_0000;
      prev6_q     <= 1'b0;
      have_prev_q <= 1'b0;
    end else if (clk_en) begin
      unique case (st_q)
        fcs_st_idle: begin
          if (go) begin
            cmd_q   <= fcs_cmd_type'(pwdata[`FCS_CMD_MSB:0]);
            step_q  <= 3'd0;
            polls_q <= 32'h0000_0000;
            st_q    <= fcs_st_issue;
          end
        end
        fcs_st_issue: begin
          if (taken)
            st_q <= fcs_st_wait;
        end
        fcs_st_wait: begin
          // A whole unlock pattern is always sent, never broken midway
          if (cyc_done) begin
            if (!last) begin
              step_q <= step_q + 3'd1;
              st_q   <= fcs_st_issue;
            end else if (fcs_timed(cmd_q)) begin
              have_prev_q <= 1'b0;
              st_q        <= fcs_st_poll;
            end else begin
              if (cmd_q == fcs_cmd_read)
                rdata_q <= cyc_rdata;
              st_q <= fcs_st_idle;
            end
          end
        end
        fcs_st_poll: begin
          if (taken)
            st_q <= fcs_st_pwait;
        end
        fcs_st_pwait: begin
          // Erase needs no exit command; polling alone ends it
          if (cyc_done) begin
            polls_q     <= polls_q + 32'd1;
            rdata_q     <= cyc_rdata;
            prev6_q     <= cyc_rdata[`FCS_TOGGLE_BIT];
            have_prev_q <= 1'b1;
            st_q        <= stop ? fcs_st_idle : fcs_st_poll;
          end
        end
        default: st_q <= fcs_st_idle;
      endcase
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  unlock_first_a: assert property (taken && cyc_req.wr && cmd_q != fcs_cmd_id_exit1
      && !(cmd_q == fcs_cmd_prog && step_q == 3'd3) && (step_q == 3'd0 || step_q == 3'd3)
      |-> cyc_req.addr == `FCS_UNLOCK_A1 && cyc_req.data == `FCS_KEY1)
    else $error("bad first unlock write");
  unlock_second_a: assert property (taken && cyc_req.wr && (step_q == 3'd1 || step_q == 3'd4)
      |-> cyc_req.addr == `FCS_UNLOCK_A2 && cyc_req.data == `FCS_KEY2)
    else $error("bad second unlock write");
  // Polling keeps the last step count, so step checks only look at issued writes
  main_erase_code_a: assert property (taken && st_q == fcs_st_issue
      && cmd_q == fcs_cmd_main_erase && step_q == 3'd5 |-> cyc_req.data == `FCS_CODE_MAIN)
    else $error("main erase confirm code wrong");
  lock_code_a: assert property (taken && st_q == fcs_st_issue && cmd_q == fcs_cmd_lock
      && step_q == 3'd5 |-> cyc_req.data == `FCS_CODE_LOCK && cyc_req.addr == `FCS_UNLOCK_A1)
    else $error("lockout confirm code wrong");
  id_entry_code_a: assert property (taken && cmd_q == fcs_cmd_id_entry && step_q == 3'd2
      |-> cyc_req.data == `FCS_CODE_ID)
    else $error("identification entry code wrong");
  // Three edges when running; the rest of the window allows for clock-enable stalls
  exit_single_a: assert property (go && pwdata[`FCS_CMD_MSB:0] == 3'(fcs_cmd_id_exit1)
      |-> ##[1:24] (wr_strobe_n == 1'b0 && word_data_lines_o == `FCS_CODE_EXIT))
    else $error("single exit write missing");
  upper_byte_zero_a: assert property (taken && cyc_req.wr
      && !(cmd_q == fcs_cmd_prog && step_q == 3'd3) |-> cyc_req.data[15:8] == 8'h00)
    else $error("command write with nonzero upper byte");
  poll_end_a: assert property ($fell(busy) && fcs_timed(cmd_q)
      |-> rdata_q[`FCS_TOGGLE_BIT] == $past(prev6_q) && polls_q >= 32'd2)
    else $error("timed command ended before toggle stopped");
  setup_code_a: assert property (taken && st_q == fcs_st_issue && step_q == 3'd2
      && fcs_len(cmd_q) == 3'd6 |-> cyc_req.data == `FCS_CODE_SETUP)
    else $error("erase or lockout setup code wrong");
  chip_erase_code_a: assert property (taken && st_q == fcs_st_issue && step_q == 3'd5
      && cmd_q == fcs_cmd_chip_erase |-> cyc_req.data == `FCS_CODE_CHIP)
    else $error("chip erase confirm code wrong");
  prog_code_a: assert property (taken && cmd_q == fcs_cmd_prog && step_q == 3'd2
      |-> cyc_req.data == `FCS_CODE_PROG && cyc_req.addr == `FCS_UNLOCK_A1)
    else $error("program setup code wrong");
  prog_target_a: assert property (taken && st_q == fcs_st_issue && step_q == 3'd3
      && cmd_q == fcs_cmd_prog |-> cyc_req.wr && cyc_req.addr == addr_q
      && cyc_req.data == data_q)
    else $error("program target word wrong");
  exit_three_code_a: assert property (taken && cmd_q == fcs_cmd_id_exit3
      && step_q == 3'd2 |-> cyc_req.data == `FCS_CODE_EXIT && cyc_req.addr == `FCS_UNLOCK_A1)
    else $error("three write exit code wrong");
  exit_single_data_a: assert property (taken && cmd_q == fcs_cmd_id_exit1
      |-> cyc_req.wr && cyc_req.addr == addr_q && cyc_req.data == `FCS_CODE_EXIT)
    else $error("single exit write wrong");
  read_target_a: assert property (taken && cmd_q == fcs_cmd_read
      |-> !cyc_req.wr && cyc_req.addr == addr_q)
    else $error("read cycle at wrong address");
  poll_read_a: assert property (taken && st_q == fcs_st_poll
      |-> !cyc_req.wr && cyc_req.addr == addr_q && fcs_timed(cmd_q))
    else $error("poll is not a read of the command address");
  operand_hold_a: assert property (busy && $past(busy)
      |-> $stable(addr_q) && $stable(data_q))
    else $error("operands moved under a running sequence");
  start_step_a: assert property (go |=> busy && step_q == 3'd0)
    else $error("command did not start at its first write");
  reject_flag_a: assert property (reject |=> rej_q)
    else $error("refused write not flagged");
  done_flag_a: assert property (finish && clk_en |=> done_q && !busy)
    else $error("finished sequence not flagged");
  idle_release_a: assert property (cyc_ready
      |-> chip_sel_n && out_gate_n && wr_strobe_n && !word_data_lines_oe)
    else $error("pins not released between cycles");
endmodule // fcs_host_ctrl
`default_nettype wire

// ==== src/fcs_pkg.sv ====
// Types shared by the flash command sequencer host
`default_nettype none
package fcs_pkg;

  typedef enum logic [2:0] {
    fcs_cmd_read, fcs_cmd_prog, fcs_cmd_chip_erase, fcs_cmd_main_erase,
    fcs_cmd_lock, fcs_cmd_id_entry, fcs_cmd_id_exit3, fcs_cmd_id_exit1
  } fcs_cmd_type;

  typedef enum logic [2:0] {
    fcs_cy_idle, fcs_cy_setup, fcs_cy_strobe, fcs_cy_hold, fcs_cy_read
  } fcs_cyc_type;

  typedef enum logic [2:0] {
    fcs_st_idle, fcs_st_issue, fcs_st_wait, fcs_st_poll, fcs_st_pwait
  } fcs_st_type;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [15:0] data;
  } fcs_req_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } fcs_pins_type;

endpackage
`default_nettype wire

// ==== verif/fcs_flash_model.sv ====
// Behavioural model of the flash device on the far side of the host pins
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model #(
  parameter logic [7:0] MAKER_CODE  = 8'h3c, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h5a, // Arbitrary value
  parameter int         PROG_NS     = 2000,
  parameter int         ERASE_NS    = 6000,
  parameter int         ACC_NS      = 45,
  parameter int         GLITCH_NS   = 15
) (
  input  wire logic [15:0] addr,
  input  wire logic [15:0] host_dq,
  input  wire logic        host_oe,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  output logic      [15:0] bus_dq,
  output logic             fault_q
);
  logic [15:0] mem [0:65535];
  logic [15:0] la, last_a, last_d, rd, rd_late;
  logic [3:0]  step;
  logic        idm, locked, busy, tog, inwr;
  realtime     t0;
  int          dur;
  wire logic   dev_oe = !ce_n && !oe_n && we_n;

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 16'hffff;
    {step, idm, locked, busy, tog, inwr, fault_q} = '0;
    {last_a, last_d} = '0;
  end

  task automatic start(input int ns);
    dur = ns;
    busy = 1'b1;
  endtask
  // Self-timed, then back to read mode with no host action
  always @(posedge busy) begin
    #(dur);
    busy = 1'b0;
  end
  task automatic wipe(input int lo);
    for (int i = lo; i < 65536; i++) mem[i] = 16'hffff;
    start(ERASE_NS);
  endtask

  task automatic take(input logic [15:0] a, input logic [15:0] d);
    logic [7:0] c;
    logic [3:0] s;
    c = d[7:0];
    s = step;
    if (busy) return;
    if (s == 4'd9) begin
      if (!(locked && a <= 16'h1fff)) mem[a] = mem[a] & d;
      last_a = a;
      last_d = d;
      step = 4'd0;
      start(PROG_NS);
    end else if (c == 8'hf0 && !(s == 4'd2 && a == 16'h5555)) begin
      idm = 1'b0;
      step = 4'd0;
    end else if (s == 4'd0 || s == 4'd3) begin
      step = (a == 16'h5555 && c == 8'haa) ? s + 4'd1 : 4'd0;
    end else if (s == 4'd1 || s == 4'd4) begin
      step = (a == 16'h2aaa && c == 8'h55) ? s + 4'd1 : 4'd0;
    end else begin
      step = 4'd0;
      if (a == 16'h5555) begin
        case ({s, c})
          12'h280: step = 4'd3;
          12'h2a0: step = 4'd9;
          12'h290: idm = 1'b1;
          12'h2f0: idm = 1'b0;
          12'h510: wipe(locked ? 32'h2000 : 32'h0);
          12'h530: wipe(32'h2000);
          12'h540: begin
            locked = 1'b1;
            start(PROG_NS);
          end
          default: step = 4'd0;
        endcase
      end
    end
  endtask

  // A write needs gate high and both strobes low long enough
  always @(negedge we_n or negedge ce_n) begin
    if (!we_n && !ce_n) begin
      inwr = oe_n;
      la = addr;
      t0 = $realtime;
    end
  end
  always @(posedge we_n or posedge ce_n) begin
    if (inwr && $realtime - t0 >= GLITCH_NS) take(la, host_dq);
    inwr = 1'b0;
  end

  // Select and gate fall in one step; only their joint edge counts as a read
  always @(posedge dev_oe) if (busy) tog = ~tog;
  always @(addr or oe_n or ce_n or busy or tog or idm or locked) begin
    rd = mem[addr];
    if (idm && addr == 16'h0002) rd = {15'h0, locked};
    if (idm && addr < 16'h0002) rd = {8'h00, addr[0] ? DEVICE_CODE : MAKER_CODE};
    if (busy) rd[6] = tog;
    if (busy && addr == last_a) rd[7] = ~last_d[7];
  end
  assign #(ACC_NS) rd_late = rd;
  // Released bus shows no stale value
  assign bus_dq = host_oe ? host_dq : (dev_oe ? rd_late : ~rd_late);
  always @(posedge dev_oe) if (host_oe) fault_q = 1'b1;
  always @(posedge host_oe) if (dev_oe) fault_q = 1'b1;
endmodule // fcs_flash_model
`default_nettype wire

// ==== verif/flash_command_sequencer_tb.sv ====
// Self-checking bench for the APB flash command sequencer host
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"
module flash_command_sequencer_tb;
  localparam logic [7:0] MAKER  = 8'h3c; // Arbitrary value
  localparam logic [7:0] DEVICE = 8'h5a; // Arbitrary value
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic        oe, ce_n, oe_n, we_n, fault;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [31:0] rnd_s = 32'd16;
  logic [15:0] pa, dout, din, ma, ba, md, bd, fa, fd;
  logic [64:0] exp_q[$];
  int          bad_count, check_count;

  fcs_host_ctrl i_fcs_host_ctrl (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .word_address_lines(pa),
    .word_data_lines_o(dout), .word_data_lines_oe(oe), .word_data_lines_i(din),
    .chip_sel_n(ce_n), .out_gate_n(oe_n), .wr_strobe_n(we_n));
  fcs_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) i_fcs_flash_model (
    .addr(pa), .host_dq(dout), .host_oe(oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .bus_dq(din), .fault_q(fault));

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    rnd_s = rnd_s ^ (rnd_s << 13);
    rnd_s = rnd_s ^ (rnd_s >> 17);
    rnd_s = rnd_s ^ (rnd_s << 5);
    return rnd_s;
  endfunction
  // Random stalls stretch both bus and pin timing
  always @(posedge pclk) clk_en <= |(rnd() & 32'h7);

  task automatic fail(input string m);
    bad_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) fail(m);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    {psel, penable} <= 2'b00;
    if (n == 64) begin
      fail("no ready");
      wrap_up();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic err);
    exp_q.push_back({err, m, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic cmp_reg(input logic [64:0] n);
    if (n[63:32] != 32'h0) begin
      check_count++;
      if ((prdata & n[63:32]) !== n[31:0] || pslverr !== n[64]) fail("read mismatch");
    end
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) cmp_reg(exp_q.pop_front());
  end

  task automatic idle();
    int k;
    for (k = 0; k < 4000; k++) begin
      rd(`FCS_OFF_STAT, 32'h0, 32'h0, 1'b0);
      if (r[0] === 1'b0) break;
    end
    if (k == 4000) begin
      fail("still busy");
      wrap_up();
    end
  endtask
  task automatic fcmd(input logic [2:0] c, input logic [15:0] a, input logic [15:0] d);
    wr(`FCS_OFF_ADDR, {16'h0, a});
    wr(`FCS_OFF_WDATA, {16'h0, d});
    wr(`FCS_OFF_CTRL, {29'h0, c});
    idle();
  endtask
  task automatic fread(input logic [15:0] a, input logic [15:0] e);
    fcmd(3'd0, a, 16'h0);
    rd(`FCS_OFF_RDATA, {16'h0, e}, 32'hffffffff, 1'b0);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, bad_count, check_count} = {1'b0, 64'd0};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk({ce_n, oe_n, we_n, oe} === 4'b1110, "pins not idle");
    rd(`FCS_OFF_STAT, 32'h0, 32'hffffffff, 1'b0);
    rd(12'h020, 32'h0, 32'hffffffff, 1'b1);
    $display("test reset done");
    ma = rnd_s[15:0] | 16'h2000;
    md = rnd_s[31:16];
    fcmd(3'd1, ma, md);
    rd(`FCS_OFF_STAT, 32'h2, 32'h3, 1'b0);
    wr(`FCS_OFF_STAT, 32'h6);
    fread(ma, md);
    fd = rnd_s[15:0];
    fcmd(3'd1, ma, fd);
    md = md & fd;
    fread(ma, md);
    $display("test program done");
    fa = ma ^ 16'h0001;
    wr(`FCS_OFF_ADDR, {16'h0, fa});
    wr(`FCS_OFF_WDATA, 32'h0);
    wr(`FCS_OFF_CTRL, 32'h1);
    wr(`FCS_OFF_ADDR, {16'h0, ma});
    idle();
    rd(`FCS_OFF_STAT, 32'h4, 32'h4, 1'b0);
    wr(`FCS_OFF_STAT, 32'h6);
    fread(fa, 16'h0);
    $display("test refusal done");
    fcmd(3'd5, 16'h0, 16'h0);
    fread(16'h0, {8'h0, MAKER});
    fread(16'h1, {8'h0, DEVICE});
    fread(16'h2, 16'h0);
    fcmd(3'd7, 16'h1234, 16'h0);
    fread(ma, md);
    $display("test ident done");
    ba = rnd_s[15:0] & 16'h1fff;
    bd = rnd_s[31:16];
    fcmd(3'd1, ba, bd);
    fcmd(3'd2, 16'h0, 16'h0);
    fread(ba, 16'hffff);
    fread(ma, 16'hffff);
    fcmd(3'd1, ba, bd);
    fcmd(3'd4, 16'h0, 16'h0);
    fcmd(3'd1, ba, 16'h0);
    fread(ba, bd);
    fcmd(3'd5, 16'h0, 16'h0);
    fread(16'h2, 16'h1);
    fcmd(3'd6, 16'h0, 16'h0);
    fread(ba, bd);
    $display("test lockout done");
    fcmd(3'd1, ma, 16'h00ff);
    fcmd(3'd3, 16'h0, 16'h0);
    fread(ma, 16'hffff);
    fread(ba, bd);
    fcmd(3'd1, ma, 16'h0);
    fcmd(3'd2, 16'h0, 16'h0);
    fread(ma, 16'hffff);
    fread(ba, bd);
    chk(fault === 1'b0, "bus contention");
    $display("test erase done");
    wrap_up();
  end
endmodule // flash_command_sequencer_tb
`default_nettype wire
